// [rtl/lcd_timing_pkg.sv]
// lcd_timing_pkg: register map, reset values, field layout and carrier types
// for the panel timing block; shared by the block and its bench.
package lcd_timing_pkg;

   localparam int CNT_W = 12;

   // register byte addresses on the wishbone port
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_HTIME = 8'h04;
   localparam logic [7:0] ADDR_HPORCH = 8'h08;
   localparam logic [7:0] ADDR_VTIME = 8'h0c;
   localparam logic [7:0] ADDR_VPORCH = 8'h10;
   localparam logic [7:0] ADDR_BGCOL = 8'h14;
   localparam logic [7:0] ADDR_STATUS = 8'h18;

   // control register bit positions
   localparam int CTRL_EN = 0;
   localparam int CTRL_HPOL = 1;
   localparam int CTRL_VPOL = 2;
   localparam int CTRL_DEPOL = 3;
   localparam int CTRL_EDGE = 4;
   localparam int CTRL_FMT_LSB = 5;
   localparam int CTRL_ENDIAN = 7;
   localparam int CTRL_BGR = 8;
   localparam int CTRL_W = 9;
   localparam logic [CTRL_W-1:0] CTRL_RST = 9'h001;

   // timing registers pack two counts: low field and high field
   localparam int LO_LSB = 0;
   localparam int HI_LSB = 16;

   // status register fields
   localparam int STAT_LINE_LSB = 0;
   localparam int STAT_PIX_LSB = 16;
   localparam int STAT_VSYNC = 31;

   localparam logic [CNT_W-1:0] H_TOTAL_RST = 12'h400;
   localparam logic [CNT_W-1:0] H_ACTIVE_RST = 12'h320;
   localparam logic [CNT_W-1:0] H_BPORCH_RST = 12'h02e;
   localparam logic [CNT_W-1:0] H_SYNC_RST = 12'h014;
   localparam logic [CNT_W-1:0] V_TOTAL_RST = 12'h20d;
   localparam logic [CNT_W-1:0] V_ACTIVE_RST = 12'h1e0;
   localparam logic [CNT_W-1:0] V_BPORCH_RST = 12'h017;
   localparam logic [CNT_W-1:0] V_SYNC_RST = 12'h00a;

   localparam logic [7:0] BG_ALPHA_RST = 8'hff;
   localparam logic [7:0] BG_RED_RST = 8'h00;
   localparam logic [7:0] BG_GREEN_RST = 8'h00;
   localparam logic [7:0] BG_BLUE_RST = 8'h00;

   localparam logic [1:0] SERIAL_LAST = 2'h2;

   typedef enum logic [1:0] {
      FMT_RGB888,
      FMT_RGB666,
      FMT_RGB565,
      FMT_SERIAL8
   } fmt_t;

   typedef struct packed {
      logic [7:0] r;
      logic [7:0] g;
      logic [7:0] b;
   } rgb_t;

   typedef struct packed {
      logic [CNT_W-1:0] htot;
      logic [CNT_W-1:0] hact;
      logic [CNT_W-1:0] hbp;
      logic [CNT_W-1:0] hsw;
      logic [CNT_W-1:0] vtot;
      logic [CNT_W-1:0] vact;
      logic [CNT_W-1:0] vbp;
      logic [CNT_W-1:0] vsw;
   } timing_cfg_t;

endpackage : lcd_timing_pkg

// [rtl/edge_sync.sv]
// edge_sync: brings a foreign clock or level into clock_in's domain and
// reports its rising and falling edges as one-cycle pulses.
// assumes the input toggles slower than half the clock_in rate.
`timescale 1ns/1ns
module edge_sync (
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic async_in,
   output logic rise_out,
   output logic fall_out
);
   logic meta_q;
   logic sync_q;
   logic last_q;

   // meta_q is read only by sync_q
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         last_q <= 1'b0;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
         last_q <= sync_q;
      end
   end

   assign rise_out = sync_q & ~last_q;
   assign fall_out = ~sync_q & last_q;

endmodule : edge_sync

// [rtl/lcd_timing_out.sv]
// lcd_timing_out: panel line/frame timing generator and pixel formatter
// with a classic wishbone register port.
// assumes panel_clk_in is slower than a quarter of clock_in and that the
// pixel source holds pix_in until pix_ready_out takes it.
`timescale 1ns/1ns
// Overview of operation
// - each line lasts a set total of panel clocks, some carrying active video
// - horizontal back porch counts from line sync start, sync included
// - line sync asserted for a set number of panel clocks at line start
// - each frame holds a set total number of lines, default 525
// - active video on a set number of lines per frame, default 480
// - vertical back porch counts from first frame sync line, sync included
// - frame sync asserted for a set number of lines at frame start
// - line sync polarity selectable, low active by default
// - frame sync polarity selectable, low active by default
// - pixel format is RGB888, RGB666, RGB565 or 8-bit serial
// - pixel data order little or big endian, little by default
// - red and blue may swap, giving RGB or BGR order
// - data enable polarity selectable, high active by default
// - sync outputs follow rising or falling panel clock edge
// - background colour shown where no pixel is supplied
module lcd_timing_out
   import lcd_timing_pkg::*;
(
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [7:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   input wire logic panel_clk_in,
   input wire rgb_t pix_in,
   input wire logic pix_valid_in,
   output logic pix_ready_out,
   output logic hsync_out,
   output logic vsync_out,
   output logic de_out,
   output logic [23:0] data_out
);

   logic [CTRL_W-1:0] ctrl_q;
   timing_cfg_t cfg_q;
   logic [31:0] bg_q;
   logic ack_q;
   logic [31:0] rdat_q;
   logic [CNT_W-1:0] hcnt_q;
   logic [CNT_W-1:0] vcnt_q;
   logic [1:0] phase_q;
   logic hsync_q;
   logic vsync_q;
   logic de_q;
   logic [23:0] data_q;
   logic pclk_rise;
   logic pclk_fall;
   logic step;
   logic enable;
   logic req;
   logic h_wrap;
   logic v_wrap;
   logic [CNT_W-1:0] nxt_h;
   logic [CNT_W-1:0] nxt_v;
   logic nxt_hact;
   logic nxt_vact;
   logic nxt_hs;
   logic nxt_vs;
   fmt_t fmt;
   rgb_t bg_rgb;
   rgb_t pix_sel;

   function automatic logic [31:0] apply_sel(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] sel);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return r;
   endfunction : apply_sel

   // start <= cnt < start + len, summed one bit wider so it cannot wrap
   function automatic logic in_range(input logic [CNT_W-1:0] cnt,
                                     input logic [CNT_W-1:0] start,
                                     input logic [CNT_W-1:0] len);
      logic [CNT_W:0] stop;
      stop = {1'b0, start} + {1'b0, len};
      return (cnt >= start) && ({1'b0, cnt} < stop);
   endfunction : in_range

   function automatic logic [31:0] pack2(input logic [CNT_W-1:0] lo,
                                         input logic [CNT_W-1:0] hi);
      logic [31:0] r;
      r = 32'h0000_0000;
      r[LO_LSB +: CNT_W] = lo;
      r[HI_LSB +: CNT_W] = hi;
      return r;
   endfunction : pack2

   function automatic logic [23:0] fmt_pixel(input rgb_t p,
                                             input fmt_t f,
                                             input logic big,
                                             input logic bgr,
                                             input logic [1:0] ph);
      logic [7:0] first;
      logic [7:0] last;
      logic [15:0] w16;
      logic [1:0] idx;
      logic [23:0] w;
      first = bgr ? p.b : p.r;
      last = bgr ? p.r : p.b;
      w16 = {first[7:3], p.g[7:2], last[7:3]};
      idx = big ? 2'(SERIAL_LAST - ph) : ph;
      w = 24'h00_0000;
      case (f)
         FMT_RGB888: begin
            w = big ? {last, p.g, first} : {first, p.g, last};
         end
         FMT_RGB666: begin
            w = big ? {6'h00, last[7:2], p.g[7:2], first[7:2]}
                    : {6'h00, first[7:2], p.g[7:2], last[7:2]};
         end
         FMT_RGB565: begin
            w = big ? {8'h00, w16[7:0], w16[15:8]}
                    : {8'h00, w16};
         end
         FMT_SERIAL8: begin
            // one component per panel clock, order set by endianness
            case (idx)
               2'h0: w = {16'h0000, first};
               2'h1: w = {16'h0000, p.g};
               default: w = {16'h0000, last};
            endcase
         end
         default: w = 24'h00_0000;
      endcase
      return w;
   endfunction : fmt_pixel

   edge_sync pclk_sync (
      .clock_in(clock_in),
      .rst_in(rst_in),
      .async_in(panel_clk_in),
      .rise_out(pclk_rise),
      .fall_out(pclk_fall)
   );

   assign enable = ctrl_q[CTRL_EN];
   assign fmt = fmt_t'(ctrl_q[CTRL_FMT_LSB +: 2]);
   assign step = enable & (ctrl_q[CTRL_EDGE] ? pclk_fall : pclk_rise);
   assign bg_rgb = rgb_t'(bg_q[23:0]);
   assign pix_sel = pix_valid_in ? pix_in : bg_rgb;

   // wishbone slave: ack one cycle after the request, data at that edge
   assign req = wb_cyc_in & wb_stb_in;
   assign wb_ack_out = ack_q;
   assign wb_dat_out = rdat_q;

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req & ~ack_q;
      end
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         rdat_q <= 32'h0000_0000;
      end else if (req & ~ack_q) begin
         case (wb_adr_in)
            ADDR_CTRL: rdat_q <= {23'h00_0000, ctrl_q};
            ADDR_HTIME: rdat_q <= pack2(cfg_q.htot, cfg_q.hact);
            ADDR_HPORCH: rdat_q <= pack2(cfg_q.hbp, cfg_q.hsw);
            ADDR_VTIME: rdat_q <= pack2(cfg_q.vtot, cfg_q.vact);
            ADDR_VPORCH: rdat_q <= pack2(cfg_q.vbp, cfg_q.vsw);
            ADDR_BGCOL: rdat_q <= bg_q;
            ADDR_STATUS: begin
               rdat_q <= pack2(vcnt_q, hcnt_q)
                         | {in_range(vcnt_q, 12'h000, cfg_q.vsw), 31'h0};
            end
            default: rdat_q <= 32'h0000_0000;
         endcase
      end
   end

   // writes land at the edge where the master sees ack
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         ctrl_q <= CTRL_RST;
         cfg_q <= '{htot: H_TOTAL_RST, hact: H_ACTIVE_RST,
                    hbp: H_BPORCH_RST, hsw: H_SYNC_RST,
                    vtot: V_TOTAL_RST, vact: V_ACTIVE_RST,
                    vbp: V_BPORCH_RST, vsw: V_SYNC_RST};
         bg_q <= {BG_ALPHA_RST, BG_RED_RST, BG_GREEN_RST, BG_BLUE_RST};
      end else if (req & ack_q & wb_we_in) begin
         case (wb_adr_in)
            ADDR_CTRL: begin
               ctrl_q <= CTRL_W'(apply_sel({23'h00_0000, ctrl_q},
                                           wb_dat_in, wb_sel_in));
            end
            ADDR_HTIME: begin
               {cfg_q.hact, cfg_q.htot} <= unpack2(apply_sel(
                  pack2(cfg_q.htot, cfg_q.hact), wb_dat_in, wb_sel_in));
            end
            ADDR_HPORCH: begin
               {cfg_q.hsw, cfg_q.hbp} <= unpack2(apply_sel(
                  pack2(cfg_q.hbp, cfg_q.hsw), wb_dat_in, wb_sel_in));
            end
            ADDR_VTIME: begin
               {cfg_q.vact, cfg_q.vtot} <= unpack2(apply_sel(
                  pack2(cfg_q.vtot, cfg_q.vact), wb_dat_in, wb_sel_in));
            end
            ADDR_VPORCH: begin
               {cfg_q.vsw, cfg_q.vbp} <= unpack2(apply_sel(
                  pack2(cfg_q.vbp, cfg_q.vsw), wb_dat_in, wb_sel_in));
            end
            ADDR_BGCOL: bg_q <= apply_sel(bg_q, wb_dat_in, wb_sel_in);
            default: ;
         endcase
      end
   end

   function automatic logic [2*CNT_W-1:0] unpack2(input logic [31:0] v);
      return {v[HI_LSB +: CNT_W], v[LO_LSB +: CNT_W]};
   endfunction : unpack2

   // next position; >= guards against a total shrunk below the count
   always_comb begin
      h_wrap = ({1'b0, hcnt_q} + 13'h0001) >= {1'b0, cfg_q.htot};
      v_wrap = ({1'b0, vcnt_q} + 13'h0001) >= {1'b0, cfg_q.vtot};
      nxt_h = h_wrap ? 12'h000 : CNT_W'(hcnt_q + 12'h001);
      nxt_v = vcnt_q;
      if (h_wrap) begin
         nxt_v = v_wrap ? 12'h000 : CNT_W'(vcnt_q + 12'h001);
      end
      nxt_hs = in_range(nxt_h, 12'h000, cfg_q.hsw);
      nxt_vs = in_range(nxt_v, 12'h000, cfg_q.vsw);
      // porches count from sync start; the rest is front porch
      nxt_hact = in_range(nxt_h, cfg_q.hbp, cfg_q.hact);
      nxt_vact = in_range(nxt_v, cfg_q.vbp, cfg_q.vact);
   end

   // parked on the last position so the first step lands on (0,0)
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         hcnt_q <= H_TOTAL_RST - 12'h001;
         vcnt_q <= V_TOTAL_RST - 12'h001;
      end else if (!enable) begin
         hcnt_q <= CNT_W'(cfg_q.htot - 12'h001);
         vcnt_q <= CNT_W'(cfg_q.vtot - 12'h001);
      end else if (step) begin
         hcnt_q <= nxt_h;
         vcnt_q <= nxt_v;
      end
   end

   // region flags, true when active, kept apart from pin polarity
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         hsync_q <= 1'b0;
         vsync_q <= 1'b0;
         de_q <= 1'b0;
      end else if (!enable) begin
         hsync_q <= 1'b0;
         vsync_q <= 1'b0;
         de_q <= 1'b0;
      end else if (step) begin
         hsync_q <= nxt_hs;
         vsync_q <= nxt_vs;
         de_q <= nxt_hact & nxt_vact;
      end
   end

   // serial format spends three panel clocks on each pixel
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         phase_q <= 2'h0;
      end else if (!enable || fmt != FMT_SERIAL8) begin
         phase_q <= 2'h0;
      end else if (step && nxt_hact && nxt_vact) begin
         phase_q <= (phase_q == SERIAL_LAST) ? 2'h0 : 2'(phase_q + 2'h1);
      end else if (step) begin
         phase_q <= 2'h0;
      end
   end

   assign pix_ready_out = step & nxt_hact & nxt_vact
                          & (fmt != FMT_SERIAL8 || phase_q == SERIAL_LAST);

   // blanking drives zero so stale pixels never reach the panel
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         data_q <= 24'h00_0000;
      end else if (!enable) begin
         data_q <= 24'h00_0000;
      end else if (step) begin
         data_q <= (nxt_hact & nxt_vact)
                   ? fmt_pixel(pix_sel, fmt, ctrl_q[CTRL_ENDIAN],
                               ctrl_q[CTRL_BGR], phase_q)
                   : 24'h00_0000;
      end
   end

   // polarity applied last so a change takes effect at once
   assign hsync_out = hsync_q ~^ ctrl_q[CTRL_HPOL];
   assign vsync_out = vsync_q ~^ ctrl_q[CTRL_VPOL];
   assign de_out = de_q ^ ctrl_q[CTRL_DEPOL];
   assign data_out = data_q;

   chk_line_wrap: assert property (
      @(posedge clock_in) disable iff (rst_in)
      step && ({1'b0, hcnt_q} + 13'h0001) >= {1'b0, cfg_q.htot}
      |=> hcnt_q == 12'h000)
      else $error("line counter did not wrap at line total");

   chk_hsync_start: assert property (
      @(posedge clock_in) disable iff (rst_in)
      step && h_wrap && cfg_q.hsw != 12'h000 && $stable(ctrl_q)
      |=> hsync_out == ctrl_q[CTRL_HPOL])
      else $error("line sync not active at line start");

   chk_hsync_end: assert property (
      @(posedge clock_in) disable iff (rst_in)
      enable && hcnt_q >= cfg_q.hsw ##0 $stable(hcnt_q) |-> !hsync_q)
      else $error("line sync active past its width");

   chk_frame_wrap: assert property (
      @(posedge clock_in) disable iff (rst_in)
      step && h_wrap && v_wrap |=> vcnt_q == 12'h000 && hcnt_q == 12'h000)
      else $error("frame counter did not wrap at frame total");

   chk_vsync_lines: assert property (
      @(posedge clock_in) disable iff (rst_in)
      enable && $stable(vcnt_q) && $stable(ctrl_q)
      |-> (vsync_out == ctrl_q[CTRL_VPOL]) == (vcnt_q < cfg_q.vsw))
      else $error("frame sync level disagrees with line count");

   chk_de_region: assert property (
      @(posedge clock_in) disable iff (rst_in)
      de_q |-> hcnt_q >= cfg_q.hbp && vcnt_q >= cfg_q.vbp)
      else $error("data enable outside active region");

   chk_front_porch: assert property (
      @(posedge clock_in) disable iff (rst_in)
      enable && ({1'b0, vcnt_q} >= {1'b0, cfg_q.vbp} + {1'b0, cfg_q.vact})
      |-> !de_q)
      else $error("data enable in vertical front porch");

   chk_step_edge: assert property (
      @(posedge clock_in) disable iff (rst_in)
      step |-> (ctrl_q[CTRL_EDGE] ? pclk_fall : pclk_rise))
      else $error("timing advanced on the wrong panel edge");

   chk_de_polarity: assert property (
      @(posedge clock_in) disable iff (rst_in)
      !enable ##1 !enable |-> de_out == ctrl_q[CTRL_DEPOL])
      else $error("data enable not idle at its inactive level");

   chk_narrow_fmt: assert property (
      @(posedge clock_in) disable iff (rst_in)
      step && fmt == FMT_RGB565 && $stable(ctrl_q) |=> data_q[23:16] == 8'h00)
      else $error("high bits driven in 16-bit format");

   chk_bus_ack: assert property (
      @(posedge clock_in) disable iff (rst_in)
      req && !ack_q |=> ack_q ##1 !ack_q)
      else $error("bus ack not a single cycle after request");

endmodule : lcd_timing_out

// [test/panel_model.sv]
// panel_model: stands in for the panel; makes its free running clock and
// measures sync, enable and frame geometry on the selected edge.
// assumes outputs settle well within half a panel clock period.
`timescale 1ns/1ns
module panel_model (
   input wire logic edge_sel_in,
   input wire logic hpol_in,
   input wire logic vpol_in,
   input wire logic depol_in,
   input wire logic hsync_in,
   input wire logic vsync_in,
   input wire logic de_in,
   output logic panel_clk_out
);
   int pos = 0, hcnt = 0, dcnt = 0, lines = 0, acts = 0, vsl = 0;
   int line_len = 0, hs_len = 0, de_start = 0, de_len = 0, first_act = 0;
   int frame_lines = 0, act_lines = 0, vs_lines = 0, frames = 0;
   logic hs, vs, de;
   logic hs_p = 1'h0, vs_p = 1'h0, de_p = 1'h0;
   initial panel_clk_out = 1'h0;
   // a real panel clock keeps running between frames
   always #400 panel_clk_out = ~panel_clk_out;
   // sampling on the launching edge sees the previous step, fully settled
   always @(panel_clk_out) begin
      if (panel_clk_out === !edge_sel_in) begin
         hs = (hsync_in === hpol_in);
         vs = (vsync_in === vpol_in);
         de = (de_in === !depol_in);
         if (hs && !hs_p) begin
            line_len = pos;
            pos = 0;
            if (vs && !vs_p) begin
               frame_lines = lines;
               act_lines = acts;
               vs_lines = vsl;
               lines = 0;
               acts = 0;
               vsl = 0;
               frames++;
            end
            lines++;
            if (vs) vsl++;
            vs_p = vs;
         end
         if (hs) hcnt++;
         else if (hs_p) begin
            hs_len = hcnt;
            hcnt = 0;
         end
         if (de) begin
            if (!de_p) begin
               de_start = pos;
               if (acts == 0) first_act = lines - 1;
               acts++;
            end
            dcnt++;
         end else if (de_p) begin
            de_len = dcnt;
            dcnt = 0;
         end
         hs_p = hs;
         de_p = de;
         pos++;
      end
   end
endmodule : panel_model

// [test/lcd_panel_timing_output_bench.sv]
// lcd_panel_timing_output_bench: drives the register port and pixel source,
// judges geometry through the panel model and pixel formats directly.
// assumes lcd_timing_out and panel_model are compiled alongside.
`timescale 1ns/1ns
module lcd_panel_timing_output_bench;
   import lcd_timing_pkg::*;
   logic clock_in = 1'h0;
   logic rst_in = 1'h1;
   logic wb_cyc = 1'h0, wb_stb = 1'h0, wb_we = 1'h0;
   logic [7:0] wb_adr = 8'h00;
   logic [3:0] wb_sel = 4'h0;
   logic [31:0] wb_dat = 32'h0, wb_rdata;
   logic wb_ack, panel_clk, pix_ready, hsync, vsync, de;
   rgb_t pix = 24'h123456;
   logic pix_valid = 1'h1;
   logic [23:0] data;
   logic [8:0] ctrl = CTRL_RST;
   int fail_count = 0;
   int checks = 0;
   logic [8:0] fmt_ctrl [8] = '{9'h001, 9'h101, 9'h081, 9'h021, 9'h041,
      9'h0c1, 9'h061, 9'h0e1};
   logic [23:0] fmt_exp [8] = '{24'h123456, 24'h563412, 24'h563412,
      24'h004355, 24'h0011aa, 24'h00aa11, 24'h000012, 24'h000056};
   always #50 clock_in = ~clock_in;
   lcd_timing_out dut (.clock_in(clock_in), .rst_in(rst_in),
      .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb), .wb_we_in(wb_we),
      .wb_adr_in(wb_adr), .wb_sel_in(wb_sel), .wb_dat_in(wb_dat),
      .wb_dat_out(wb_rdata), .wb_ack_out(wb_ack),
      .panel_clk_in(panel_clk), .pix_in(pix), .pix_valid_in(pix_valid),
      .pix_ready_out(pix_ready), .hsync_out(hsync), .vsync_out(vsync),
      .de_out(de), .data_out(data));
   panel_model panel (.edge_sel_in(ctrl[CTRL_EDGE]),
      .hpol_in(ctrl[CTRL_HPOL]), .vpol_in(ctrl[CTRL_VPOL]),
      .depol_in(ctrl[CTRL_DEPOL]), .hsync_in(hsync), .vsync_in(vsync),
      .de_in(de), .panel_clk_out(panel_clk));

   task automatic conclude;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : conclude

   task automatic cmp(input string what, input logic [31:0] exp,
         input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp

   task automatic give_up(input string what);
      fail_count++;
      $display("[FAIL] %s expected event seen none", what);
      conclude();
   endtask : give_up

   // request held until the edge that samples ack, data taken there
   task automatic wb_xfer(input logic [7:0] a, input logic w,
         input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge clock_in);
      wb_cyc <= 1'h1;
      wb_stb <= 1'h1;
      wb_we <= w;
      wb_adr <= a;
      wb_dat <= d;
      wb_sel <= 4'hf;
      n = 0;
      do begin
         @(posedge clock_in);
         n++;
      end while (wb_ack !== 1'h1 && n < 20);
      q = wb_rdata;
      wb_cyc <= 1'h0;
      wb_stb <= 1'h0;
      wb_we <= 1'h0;
      if (n >= 20) give_up("bus ack");
   endtask : wb_xfer

   task automatic wb_wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb_xfer(a, 1'h1, d, q);
      if (a == ADDR_CTRL) ctrl = d[8:0];
   endtask : wb_wr

   task automatic wait_de(input logic lvl);
      int k;
      k = 0;
      do begin
         @(negedge clock_in);
         k++;
      end while (de !== lvl && k < 3000);
      if (k >= 3000) give_up("data enable");
   endtask : wait_de

   task automatic t_reset_values;
      logic [31:0] q;
      logic [7:0] adr [7] = '{ADDR_CTRL, ADDR_HTIME, ADDR_HPORCH,
         ADDR_VTIME, ADDR_VPORCH, ADDR_BGCOL, 8'h1c};
      logic [31:0] exp [7] = '{32'h001, 32'h0320_0400, 32'h0014_002e,
         32'h01e0_020d, 32'h000a_0017, 32'hff00_0000, 32'h0};
      for (int i = 0; i < 7; i++) begin
         wb_xfer(adr[i], 1'h0, 32'h0, q);
         cmp("reset value", exp[i], q);
      end
   endtask : t_reset_values

   // parked outputs must sit at their inactive levels
   task automatic t_disable_setup;
      wb_wr(ADDR_CTRL, 32'h0);
      repeat (3) @(posedge panel_clk);
      @(negedge clock_in);
      cmp("parked line sync", 32'h1, {31'h0, hsync});
      cmp("parked frame sync", 32'h1, {31'h0, vsync});
      cmp("parked enable", 32'h0, {31'h0, de});
      wb_wr(ADDR_HTIME, 32'h0006_0010);
      wb_wr(ADDR_HPORCH, 32'h0002_0005);
      wb_wr(ADDR_VTIME, 32'h0003_0008);
      wb_wr(ADDR_VPORCH, 32'h0001_0003);
   endtask : t_disable_setup

   task automatic check_geometry(input logic [31:0] c);
      int start, k;
      wb_wr(ADDR_CTRL, c);
      start = panel.frames;
      k = 0;
      while (panel.frames < start + 3 && k < 20000) begin
         @(posedge clock_in);
         k++;
      end
      if (k >= 20000) give_up("frame start");
      cmp("line length", 32'd16, panel.line_len);
      cmp("line sync width", 32'd2, panel.hs_len);
      cmp("first active pixel", 32'd5, panel.de_start);
      cmp("active pixels", 32'd6, panel.de_len);
      cmp("frame lines", 32'd8, panel.frame_lines);
      cmp("active lines", 32'd3, panel.act_lines);
      cmp("first active line", 32'd3, panel.first_act);
      cmp("frame sync lines", 32'd1, panel.vs_lines);
   endtask : check_geometry

   task automatic t_formats;
      for (int i = 0; i < 8; i++) begin
         wb_wr(ADDR_CTRL, {23'h0, fmt_ctrl[i]});
         wait_de(1'h0);
         cmp("blank data", 32'h0, {8'h0, data});
         wait_de(1'h1);
         cmp("pixel format", {8'h0, fmt_exp[i]}, {8'h0, data});
      end
   endtask : t_formats

   task automatic t_background;
      logic [31:0] q;
      wb_wr(ADDR_BGCOL, 32'hffab_cdef);
      wb_xfer(ADDR_BGCOL, 1'h0, 32'h0, q);
      cmp("background register", 32'hffab_cdef, q);
      wb_wr(ADDR_CTRL, 32'h001);
      pix_valid <= 1'h0;
      wait_de(1'h0);
      wait_de(1'h1);
      cmp("background colour", 32'h00ab_cdef, {8'h0, data});
   endtask : t_background

   initial begin
      repeat (12) @(posedge clock_in);
      rst_in <= 1'h0;
      t_reset_values();
      t_disable_setup();
      check_geometry(32'h001);
      // every polarity inverted and the falling panel edge selected
      check_geometry(32'h01f);
      t_formats();
      t_background();
      conclude();
   end
endmodule : lcd_panel_timing_output_bench
